// *** bench/reg_host.sv ***
`timescale 1ns/10ps
`default_nettype none

module reg_host
   import alarm_pkg::*;
(
   input  wire logic       clock,           // System clock
   input  wire logic [1:0] resolution_code, // Current resolution
   output var  reg_req_t   req              // Register strobes
);
   // ------------
   // Bus cycles
   // ------------
   // Idle at time zero
   initial req = '0;

   // One strobe cycle, launched and dropped on falling edges
   task automatic access(input logic w, input logic [7:0] p, input logic [15:0] d);
      @(negedge clock);
      req <= '{wr: w, rd: ~w, ptr: p, wdata: d};
      @(negedge clock);
      // Released pointer and data show garbage, not the last value
      req <= '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
   endtask

   // Limit write in quarter degrees, unused bits zero
   task automatic put_limit(input logic [7:0] p, input logic [10:0] q);
      logic [10:0] v;
      v = q;
      if (resolution_code == 2'h0) v[0] = 1'b0;
      access(1'b1, p, {3'h0, v, 2'h0});
   endtask
endmodule

`default_nettype wire

// *** bench/thermal_limit_alarm_logic_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "alarm_consts.svh"

module thermal_limit_alarm_logic_test
   import alarm_pkg::*;
;
   // ------------
   // Signals
   // ------------
   logic        clock = 1'b0;            // 100 MHz
   logic        reset = 1'b1;            // Power-on reset
   reg_req_t    req;                     // From host model
   logic [12:0] sample = '0;             // Converter result
   logic        sample_valid = 1'b0;     // Result pulse
   logic [1:0]  resolution_code = 2'h1;  // Random per sample
   logic [15:0] rdata;                   // Read data
   logic        rvalid;                  // Read answer
   logic        alarm_o;                 // Pin level
   logic        alarm_oe;                // Pin drive
   logic        shutdown_active;         // Converter stop
   logic [15:0] expq[$];                 // Expected read words
   int          fail_count = 0;          // Mismatches
   int          samples_checked = 0;     // Comparisons
   int          cycles = 0;              // Hang guard
   logic [31:0] lfsr = 32'h0e4f8348;     // Random state
   logic [12:0] last_s = '0;             // Held temperature
   logic        frozen = 1'b0;           // Shutdown expected
   logic [10:0] t_hi = 11'd100;          // 25 C
   logic [10:0] t_lo = 11'd40;           // 10 C
   logic [10:0] t_crit = 11'd400;        // 100 C
   logic [10:0] hq;                      // Hysteresis in quarters
   logic [10:0] hyst_tab [4] = '{11'h0, 11'h6, 11'hc, 11'h18};

   always #5 clock = ~clock;

   thermal_limit_alarm_logic thermal_limit_alarm_logic_i (
      .clock(clock), .reset(reset), .req(req), .sample(sample),
      .sample_valid(sample_valid), .resolution_code(resolution_code),
      .rdata(rdata), .rvalid(rvalid), .alarm_o(alarm_o),
      .alarm_oe(alarm_oe), .shutdown_active(shutdown_active));

   reg_host reg_host_i (.clock(clock), .resolution_code(resolution_code), .req(req));

   // ------------
   // Helpers
   // ------------
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask

   // Note the answer first, then issue the read
   task automatic rd(input logic [7:0] p, input logic [15:0] want);
      expq.push_back(want);
      reg_host_i.access(1'b0, p, 16'h0);
   endtask

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      reg_host_i.access(1'b1, p, d);
   endtask

   // Pin is looked at after status has had time to settle
   task automatic pin(input logic want);
      repeat (3) @(negedge clock);
      check("alarm_oe", {15'h0, alarm_oe}, {15'h0, want});
      check("alarm_o", {15'h0, alarm_o}, 16'h0000);
   endtask

   // One sample, random fraction bits and resolution, then a data read
   task automatic temp_step(input logic [10:0] q, input logic [2:0] fl);
      logic [12:0] s;
      logic [12:0] m;
      lfsr = next_rand(lfsr);
      s = {q, lfsr[1:0]};
      m = (lfsr[3:2] == 2'h0) ? `MASK_RES0 : (lfsr[3:2] == 2'h1) ? `MASK_RES1 :
          (lfsr[3:2] == 2'h2) ? `MASK_RES2 : `MASK_RES3;
      if (!frozen) last_s = s;
      @(negedge clock);
      sample <= s;
      sample_valid <= 1'b1;
      resolution_code <= lfsr[3:2];
      @(negedge clock);
      sample_valid <= 1'b0;
      sample <= ~s;
      repeat (2) @(negedge clock);
      rd(`ADDR_TEMP, {fl, last_s & m});
   endtask

   // ------------
   // Scoreboard and ending
   // ------------
   // Oldest note against each read answer
   always @(negedge clock) begin
      if (rvalid === 1'b1) begin
         if (expq.size() > 0) check("rdata", rdata, expq.pop_front());
         else check("stray answer", 16'h0, 16'hffff);
      end
   end

   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs a few hundred cycles at most
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   // ------------
   // Scenarios
   // ------------
   initial begin
      repeat (8) @(negedge clock);
      reset <= 1'b0;
      rd(`ADDR_CFG, `CFG_RESET);
      rd(`ADDR_HI, 16'h0);
      rd(`ADDR_CRIT, 16'h0);
      rd(8'h09, 16'h0);
      pin(1'b0);
      wr(`ADDR_HI, 16'hffff);
      rd(`ADDR_HI, 16'h1ffc);
      reg_host_i.put_limit(`ADDR_HI, t_hi);
      reg_host_i.put_limit(`ADDR_LO, t_lo);
      reg_host_i.put_limit(`ADDR_CRIT, t_crit);
      rd(`ADDR_LO, {3'h0, t_lo, 2'h0});
      // Both window edges at every hysteresis code
      for (int h = 0; h < 4; h++) begin
         hq = hyst_tab[h];
         wr(`ADDR_CFG, {5'h0, h[1:0], 9'h0});
         temp_step(t_hi + 11'h1, 3'b010);
         temp_step(t_hi - hq + 11'h1, 3'b010);
         temp_step(t_hi - hq, 3'b000);
         temp_step(t_lo - hq, 3'b000);
         temp_step(t_lo - hq - 11'h1, 3'b001);
         temp_step(t_lo - 11'h1, 3'b001);
         temp_step(t_lo, 3'b000);
      end
      // Comparator, critical only, polarity
      wr(`ADDR_CFG, 16'h020c);
      temp_step(t_hi + 11'h1, 3'b010);
      pin(1'b0);
      temp_step(t_crit + 11'h1, 3'b110);
      pin(1'b1);
      rd(`ADDR_CFG, 16'h021c);
      temp_step(t_crit - 11'h5, 3'b110);
      wr(`ADDR_CFG, 16'h022c);
      pin(1'b1);
      wr(`ADDR_CFG, 16'h020e);
      pin(1'b0);
      temp_step(t_crit - 11'h6, 3'b010);
      pin(1'b1);
      wr(`ADDR_CFG, 16'h0208);
      pin(1'b1);
      temp_step(t_hi - 11'h6, 3'b000);
      pin(1'b0);
      // Interrupt latch and clear
      wr(`ADDR_CFG, 16'h0209);
      temp_step(t_hi + 11'h1, 3'b010);
      temp_step(t_hi - 11'h6, 3'b000);
      pin(1'b1);
      wr(`ADDR_CFG, 16'h0229);
      pin(1'b0);
      rd(`ADDR_CFG, 16'h0209);
      // Shutdown freezes data and alarms
      wr(`ADDR_CFG, 16'h0309);
      frozen = 1'b1;
      check("shutdown_active", {15'h0, shutdown_active}, 16'h0001);
      temp_step(t_crit + 11'h1, 3'b000);
      pin(1'b0);
      wr(`ADDR_CFG, 16'h0209);
      frozen = 1'b0;
      // Window lock, then critical lock
      wr(`ADDR_CFG, 16'h0248);
      reg_host_i.put_limit(`ADDR_HI, 11'd200);
      rd(`ADDR_HI, {3'h0, t_hi, 2'h0});
      wr(`ADDR_CFG, 16'h0506);
      rd(`ADDR_CFG, 16'h024a);
      reg_host_i.put_limit(`ADDR_CRIT, 11'd300);
      wr(`ADDR_CFG, 16'h02c8);
      reg_host_i.put_limit(`ADDR_CRIT, 11'd500);
      rd(`ADDR_CRIT, {3'h0, 11'd300, 2'h0});
      wr(`ADDR_CFG, 16'h0008);
      rd(`ADDR_CFG, 16'h02c8);
      // Only a power-on reset unlocks the limits
      @(negedge clock);
      reset <= 1'b1;
      repeat (2) @(negedge clock);
      reset <= 1'b0;
      rd(`ADDR_CFG, `CFG_RESET);
      reg_host_i.put_limit(`ADDR_CRIT, 11'd500);
      rd(`ADDR_CRIT, {3'h0, 11'd500, 2'h0});
      repeat (3) @(negedge clock);
      check("pending reads", 16'(expq.size()), 16'h0);
      conclude();
   end
endmodule

`default_nettype wire

// *** logic/alarm_consts.svh ***
// How it works
// - Hysteresis code picks 0, 1.5, 3, 6 degrees
// - Above flag sets over high, clears at or below high-hyst
// - Below flag sets under low-hyst, clears at low
// - Critical alarm holds until at or below limit minus hysteresis
// - Shutdown freezes data and alarms, bus still answers
// - Locks block setting shutdown, clearing always allowed
// - Critical lock freezes critical limit until power-up
// - Window lock freezes high and low limits
// - Clear bit releases latched alarm, reads zero
// - Status bit mirrors alarm assertion, zero after reset
// - Enable defaults off, frozen under either lock
// - Critical-only bit masks window alarms, window-locked
// - Polarity bit selects asserted pin level
// - Mode bit: comparator or interrupt, interrupt default
// - Limits and temperature in two's complement quarters
// - Comparisons use only bits twelve down to two
// - Limit layout sign bit twelve, unused bits zero
// - Hysteresis in bits ten to nine, lock-frozen
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// ----------------------------------------
// Register pointers
// ----------------------------------------
`define ADDR_CFG   8'h01
`define ADDR_HI    8'h02
`define ADDR_LO    8'h03
`define ADDR_CRIT  8'h04
`define ADDR_TEMP  8'h05

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define CFG_RESET  16'h0001
`define HYST_MSB   10
`define HYST_LSB   9
`define BIT_SHUTDOWN 8
`define BIT_CLOCK  7
`define BIT_WLOCK  6
`define BIT_CLEAR  5
`define BIT_STS    4
`define BIT_EN     3
`define BIT_CONLY  2
`define BIT_POL    1
`define BIT_MODE   0

// ----------------------------------------
// Temperature fields, quarter-degree units
// ----------------------------------------
`define LIM_MSB    12
`define LIM_LSB    2
`define HYST_1P5   12'sh006
`define HYST_3P0   12'sh00c
`define HYST_6P0   12'sh018
`define MASK_RES0  13'h1ff8
`define MASK_RES1  13'h1ffc
`define MASK_RES2  13'h1ffe
`define MASK_RES3  13'h1fff

`endif

// *** logic/alarm_pkg.sv ***
`default_nettype none
package alarm_pkg;

   // ----------------------------------------
   // Bus request and control types
   // ----------------------------------------
   typedef struct packed {
      logic        wr;     // Write strobe
      logic        rd;     // Read strobe
      logic [7:0]  ptr;    // Register pointer
      logic [15:0] wdata;  // Write data
   } reg_req_t;

   typedef struct packed {
      logic [1:0] hyst;      // Hysteresis select
      logic       shutdown_bit; // Shutdown
      logic       crit_lock; // Critical lock
      logic       win_lock;  // Window lock
      logic       en;        // Alarm enable
      logic       crit_only; // Critical only
      logic       pol;       // Alarm polarity
      logic       mode;      // 1 interrupt, 0 comparator
   } ctrl_t;

   typedef struct packed {
      logic above; // Above window
      logic below; // Below window
      logic crit;  // Above critical
   } flags_t;

   typedef struct packed {
      ctrl_t       ctrl;     // Control bits
      logic [10:0] hi;       // Upper window limit
      logic [10:0] lo;       // Lower window limit
      logic [10:0] crit_lim; // Critical limit
      logic [12:0] temp;     // Held temperature
      flags_t      flags;    // Limit conditions
      logic        latch;    // Interrupt latch
      logic        status;   // Alarm asserted
      logic        pin_oe;   // Pin drive low
      logic        rvalid;   // Read answer
      logic [15:0] rdata;    // Read data
   } state_t;

endpackage
`default_nettype wire

// *** logic/thermal_limit_alarm_logic.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "alarm_consts.svh"

module thermal_limit_alarm_logic
   import alarm_pkg::*;
(
   input  wire logic        clock,           // System clock
   input  wire logic        reset,           // Power-on reset
   input  wire reg_req_t    req,             // Decoded register access
   input  wire logic [12:0] sample,          // Converter result
   input  wire logic        sample_valid,    // New result pulse
   input  wire logic [1:0]  resolution_code, // Converter resolution
   output logic [15:0]      rdata,           // Read data
   output logic             rvalid,          // Read answer pulse
   output logic             alarm_o,         // Alarm pin output level
   output logic             alarm_oe,        // Alarm pin pulled low
   output logic             shutdown_active  // Converter stop
);

   // ----------------------------------------
   // State and working signals
   // ----------------------------------------
   state_t             s_q;       // Registered state
   state_t             s_d;       // Next state
   logic               lock_any;  // Either lock set
   logic               cfg_wr;    // Control write
   logic [15:0]        wd;        // Write data
   logic signed [11:0] hyst_amt;  // Hysteresis in quarters
   logic signed [11:0] t;         // Compared temperature
   logic signed [11:0] hi;        // Upper limit, extended
   logic signed [11:0] lo;        // Lower limit, extended
   logic signed [11:0] cr;        // Critical limit, extended
   logic               new_evt;   // Fresh interrupt condition
   logic               clr;       // Clear request
   logic               win_cond;  // Window alarm wanted
   logic [12:0]        res_mask;  // Read resolution mask

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.rvalid = 1'b0;
      lock_any = s_q.ctrl.crit_lock | s_q.ctrl.win_lock;
      cfg_wr   = req.wr && (req.ptr == `ADDR_CFG);
      wd       = req.wdata;
      // Hysteresis decode, absolute amount below a limit
      unique case (s_q.ctrl.hyst)
         2'b00: hyst_amt = 12'sh000;
         2'b01: hyst_amt = `HYST_1P5;
         2'b10: hyst_amt = `HYST_3P0;
         2'b11: hyst_amt = `HYST_6P0;
      endcase
      // Only bits 12..2 compare, finer bits are read-only detail
      t  = $signed({sample[`LIM_MSB], sample[`LIM_MSB:`LIM_LSB]});
      hi = $signed({s_q.hi[10], s_q.hi});
      lo = $signed({s_q.lo[10], s_q.lo});
      cr = $signed({s_q.crit_lim[10], s_q.crit_lim});

      // Control writes
      if (cfg_wr) begin
         // Locks are sticky until power-on reset
         s_d.ctrl.crit_lock = s_q.ctrl.crit_lock | wd[`BIT_CLOCK];
         s_d.ctrl.win_lock  = s_q.ctrl.win_lock | wd[`BIT_WLOCK];
         if (!lock_any) begin
            s_d.ctrl.hyst = wd[`HYST_MSB:`HYST_LSB];
            s_d.ctrl.en   = wd[`BIT_EN];
         end
         if (!s_q.ctrl.win_lock) begin
            s_d.ctrl.crit_only = wd[`BIT_CONLY];
         end
         // Setting shutdown needs unlocked, clearing always wins
         if (!wd[`BIT_SHUTDOWN] || !lock_any) begin
            s_d.ctrl.shutdown_bit = wd[`BIT_SHUTDOWN];
         end
         s_d.ctrl.pol  = wd[`BIT_POL];
         s_d.ctrl.mode = wd[`BIT_MODE];
      end

      // Limit writes, unused bits dropped
      if (req.wr && (req.ptr == `ADDR_HI) && !s_q.ctrl.win_lock) begin
         s_d.hi = wd[`LIM_MSB:`LIM_LSB];
      end
      if (req.wr && (req.ptr == `ADDR_LO) && !s_q.ctrl.win_lock) begin
         s_d.lo = wd[`LIM_MSB:`LIM_LSB];
      end
      if (req.wr && (req.ptr == `ADDR_CRIT) && !s_q.ctrl.crit_lock) begin
         s_d.crit_lim = wd[`LIM_MSB:`LIM_LSB];
      end

      // Compare only while converting; shutdown freezes temperature and flags
      if (sample_valid && !s_q.ctrl.shutdown_bit) begin
         s_d.temp = sample;
         // Above window with hysteresis on the way down
         if (t > hi) begin
            s_d.flags.above = 1'b1;
         end else if (t <= hi - hyst_amt) begin
            s_d.flags.above = 1'b0;
         end
         // Below window with hysteresis on the way down
         if (t < lo - hyst_amt) begin
            s_d.flags.below = 1'b1;
         end else if (t >= lo) begin
            s_d.flags.below = 1'b0;
         end
         // Critical condition holds until at or below limit minus hysteresis
         if (t > cr) begin
            s_d.flags.crit = 1'b1;
         end else if (t <= cr - hyst_amt) begin
            s_d.flags.crit = 1'b0;
         end
      end

      // Interrupt latch; a new event beats a simultaneous clear
      new_evt = ((s_d.flags.above & ~s_q.flags.above) | (s_d.flags.below & ~s_q.flags.below))
                & ~s_q.ctrl.crit_only | (s_d.flags.crit & ~s_q.flags.crit);
      clr     = cfg_wr & wd[`BIT_CLEAR];
      if (!s_q.ctrl.mode) begin
         s_d.latch = 1'b0;
      end else if (new_evt) begin
         s_d.latch = 1'b1;
      end else if (clr) begin
         s_d.latch = 1'b0;
      end

      // Alarm decision; critical stays asserted in both modes
      win_cond   = ~s_q.ctrl.crit_only & (s_q.flags.above | s_q.flags.below);
      s_d.status = s_q.ctrl.en & (s_q.flags.crit | (s_q.ctrl.mode ? s_q.latch : win_cond));
      // Open drain: pull low for the active-low level or, while enabled, idle-low
      // Next-cycle controls, so pin and status never disagree after a polarity write
      s_d.pin_oe = s_d.status ? ~s_d.ctrl.pol : (s_d.ctrl.en & s_d.ctrl.pol);

      // Finer temperature bits appear only in data reads
      unique case (resolution_code)
         2'b00: res_mask = `MASK_RES0;
         2'b01: res_mask = `MASK_RES1;
         2'b10: res_mask = `MASK_RES2;
         2'b11: res_mask = `MASK_RES3;
      endcase

      // Register reads, unmapped pointers return zero
      if (req.rd) begin
         s_d.rvalid = 1'b1;
         case (req.ptr)
            `ADDR_CFG: begin
               // Clear always reads zero, status mirrors alarm assertion, not the pin level
               s_d.rdata = {5'h00, s_q.ctrl.hyst, s_q.ctrl.shutdown_bit, s_q.ctrl.crit_lock,
                            s_q.ctrl.win_lock, 1'b0, s_q.status, s_q.ctrl.en,
                            s_q.ctrl.crit_only, s_q.ctrl.pol, s_q.ctrl.mode};
            end
            `ADDR_HI: begin
               s_d.rdata = {3'h0, s_q.hi, 2'h0};
            end
            `ADDR_LO: begin
               s_d.rdata = {3'h0, s_q.lo, 2'h0};
            end
            `ADDR_CRIT: begin
               s_d.rdata = {3'h0, s_q.crit_lim, 2'h0};
            end
            `ADDR_TEMP: begin
               s_d.rdata = {s_q.flags.crit, s_q.flags.above, s_q.flags.below,
                            s_q.temp & res_mask};
            end
            default: begin
               s_d.rdata = 16'h0000;
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register, synchronous power-on reset
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         s_q                <= '0;
         s_q.ctrl.hyst      <= 2'h0;
         s_q.ctrl.mode      <= 1'b1;
         s_q.ctrl.en        <= 1'b0;
         s_q.ctrl.crit_lock <= 1'b0;
         s_q.ctrl.win_lock  <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs straight from flops, pin level tied low
   // ----------------------------------------
   // Open-drain pin never drives high; the level comes from the pull-up
   assign alarm_o         = 1'b0;
   assign alarm_oe        = s_q.pin_oe;
   assign rdata           = s_q.rdata;
   assign rvalid          = s_q.rvalid;
   assign shutdown_active = s_q.ctrl.shutdown_bit;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // Quiet sample with no control write over two cycles
   sequence s_crit_hit;
      (sample_valid && !s_q.ctrl.shutdown_bit && t > cr && s_q.ctrl.en && !cfg_wr) ##1 !cfg_wr;
   endsequence

   sequence s_cfg_read;
      req.rd && req.ptr == `ADDR_CFG;
   endsequence

   property p_hyst_hold;
      (s_q.ctrl.hyst == 2'b10 && sample_valid && !s_q.ctrl.shutdown_bit && s_q.flags.above
       && t <= hi && t > hi - `HYST_3P0) |=> s_q.flags.above;
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis hold lost");

   property p_above_set;
      (sample_valid && !s_q.ctrl.shutdown_bit && t > hi) |=> s_q.flags.above;
   endproperty
   a_above_set: assert property (p_above_set) else $error("above flag not set");

   property p_above_clr;
      (sample_valid && !s_q.ctrl.shutdown_bit && t <= hi - hyst_amt) |=> !s_q.flags.above;
   endproperty
   a_above_clr: assert property (p_above_clr) else $error("above flag not cleared");

   property p_below_set;
      (sample_valid && !s_q.ctrl.shutdown_bit && t < lo - hyst_amt) |=> s_q.flags.below;
   endproperty
   a_below_set: assert property (p_below_set) else $error("below flag not set");

   property p_crit_alarm;
      s_crit_hit |=> s_q.status;
   endproperty
   a_crit_alarm: assert property (p_crit_alarm) else $error("critical alarm missing");

   property p_shutdown_freeze;
      s_q.ctrl.shutdown_bit |=> $stable(s_q.temp) && $stable(s_q.flags);
   endproperty
   a_shutdown_freeze: assert property (p_shutdown_freeze) else $error("data moved in shutdown");

   property p_shutdown_lock;
      (lock_any && !s_q.ctrl.shutdown_bit && cfg_wr) |=> !s_q.ctrl.shutdown_bit;
   endproperty
   a_shutdown_lock: assert property (p_shutdown_lock) else $error("shutdown set while locked");

   property p_crit_lock;
      s_q.ctrl.crit_lock |=> s_q.ctrl.crit_lock && $stable(s_q.crit_lim);
   endproperty
   a_crit_lock: assert property (p_crit_lock) else $error("critical limit changed");

   property p_win_lock;
      s_q.ctrl.win_lock |=> s_q.ctrl.win_lock && $stable(s_q.hi) && $stable(s_q.lo);
   endproperty
   a_win_lock: assert property (p_win_lock) else $error("window limit changed");

   property p_cfg_read;
      s_cfg_read |=> rvalid && !rdata[`BIT_CLEAR] && rdata[`BIT_STS] == $past(s_q.status);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("control read wrong");

   property p_en_lock;
      lock_any |=> $stable(s_q.ctrl.en) && $stable(s_q.ctrl.hyst);
   endproperty
   a_en_lock: assert property (p_en_lock) else $error("enable changed while locked");

   property p_pin_level;
      (s_q.status && s_q.ctrl.en && !s_q.ctrl.pol) |-> alarm_oe;
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("active-low pin not pulled");

   property p_disabled_quiet;
      (!s_q.ctrl.en && !req.wr) [*2] |-> !s_q.status && !alarm_oe;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("alarm while disabled");

   // Clearing shutdown is never refused, locked or not
   property p_shutdown_clear;
      (cfg_wr && !wd[`BIT_SHUTDOWN]) |=> !s_q.ctrl.shutdown_bit;
   endproperty
   a_shutdown_clear: assert property (p_shutdown_clear) else $error("shutdown clear refused");

   // Meeting the lower limit ends the below condition
   property p_below_clr;
      (sample_valid && !s_q.ctrl.shutdown_bit && t >= lo) |=> !s_q.flags.below;
   endproperty
   a_below_clr: assert property (p_below_clr) else $error("below flag not cleared");

   // Any sample over the critical limit outside shutdown raises the condition
   property p_crit_set;
      (sample_valid && !s_q.ctrl.shutdown_bit && t > cr) |=> s_q.flags.crit;
   endproperty
   a_crit_set: assert property (p_crit_set) else $error("critical flag not set");

   // Critical condition ends only at or below limit minus band
   property p_crit_clr;
      (sample_valid && !s_q.ctrl.shutdown_bit && t <= cr - hyst_amt) |=> !s_q.flags.crit;
   endproperty
   a_crit_clr: assert property (p_crit_clr) else $error("critical flag not cleared");

   // Fresh above-window event latches in interrupt mode
   property p_latch_set;
      (s_q.ctrl.mode && sample_valid && !s_q.ctrl.shutdown_bit && !s_q.ctrl.crit_only
       && !s_q.flags.above && t > hi) |=> s_q.latch;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("interrupt not latched");

   // Clear with no sample in flight releases the latch
   property p_clear_release;
      (s_q.ctrl.mode && cfg_wr && wd[`BIT_CLEAR] && !sample_valid) |=> !s_q.latch;
   endproperty
   a_clear_release: assert property (p_clear_release) else $error("clear did not release");

   // Comparator mode never holds a latched event
   property p_comp_no_latch;
      !s_q.ctrl.mode |=> !s_q.latch;
   endproperty
   a_comp_no_latch: assert property (p_comp_no_latch) else $error("latch held in comparator mode");

   // Comparator mode follows the window conditions
   property p_comp_follow;
      (!s_q.ctrl.mode && s_q.ctrl.en && !s_q.ctrl.crit_only && (s_q.flags.above || s_q.flags.below))
      |=> s_q.status;
   endproperty
   a_comp_follow: assert property (p_comp_follow) else $error("comparator alarm missing");

   // Critical-only hides window conditions
   property p_crit_only_mask;
      (!s_q.ctrl.mode && s_q.ctrl.crit_only && !s_q.flags.crit) |=> !s_q.status;
   endproperty
   a_crit_only_mask: assert property (p_crit_only_mask) else $error("window alarm not masked");

   // Window lock also freezes the critical-only choice
   property p_conly_lock;
      s_q.ctrl.win_lock |=> $stable(s_q.ctrl.crit_only);
   endproperty
   a_conly_lock: assert property (p_conly_lock) else $error("critical-only changed while locked");

   // Status bit and pin always tell the same story
   property p_status_pin;
      s_q.status |-> alarm_oe == !s_q.ctrl.pol;
   endproperty
   a_status_pin: assert property (p_status_pin) else $error("status and pin disagree");

   // Idle pin sits at the inverse of the asserted level while enabled, released while disabled
   property p_pin_idle;
      !s_q.status |-> alarm_oe == (s_q.ctrl.en && s_q.ctrl.pol);
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("idle pin level wrong");

   // Half-degree resolution hides the finer data bits
   property p_temp_mask;
      (req.rd && req.ptr == `ADDR_TEMP && resolution_code == 2'h0) |=> rdata[2:0] == 3'h0;
   endproperty
   a_temp_mask: assert property (p_temp_mask) else $error("fine bits shown at coarse resolution");

   // High-limit reads keep unused bits at zero
   property p_limit_layout;
      (req.rd && req.ptr == `ADDR_HI) |=> rdata[15:13] == 3'h0 && rdata[1:0] == 2'h0;
   endproperty
   a_limit_layout: assert property (p_limit_layout) else $error("limit unused bits set");

endmodule
`default_nettype wire
